/* File: logic/fan_ramp_boost_smoothing.sv */
// Notes on behaviour
// - regulator-overheat ramp uses low nibble of ramp pacing as step wait
// - processor-throttle ramp uses high nibble of ramp pacing as step wait
// - a zero step wait jumps the duty straight to full, and straight back to base duty on release
// - first pair boost hysteresis is bits 3:0 of first register, 1 degree
// - second pair boost hysteresis is bits 7:4 of first register, 1 degree
// - zone three boost hysteresis is bits 3:0 of second register
// - zone four boost hysteresis is bits 7:4 of second register
// - after boost, hold full duty until temperature falls by hysteresis
// - hysteresis fields are unsigned, zero to fifteen degrees
// - bits 2:0 of smoothing select first pair filter span, 12.8 to 0.4 s
// - bits 6:4 select second pair span with the same mapping
// - bit 3 makes first pair limits and fan control use filtered value
// - bit 7 makes second pair limits and fan control use filtered value
// - filtered temperatures keep updating even while use bit is clear
// - ordinary readings stay unfiltered while smoothing is on
// - smoothing runs on top of converter averaging, separately
// - general input threshold bits 2 and 3 act only in legacy VID mode
`timescale 1ns/1ps
`default_nettype none
`include "fan_ramp_regs.svh"
module fan_ramp_boost_smoothing #(
    parameter int TICK_CYCLES = `CLK_KHZ * `STEP_MS,
    parameter int RAMP_STEP   = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // register port from the serial engine
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata_q,
    // pins
    input  wire logic             regulator_overheat_input,
    input  wire logic             processor_throttle_signal,
    // from converter and fan control
    input  wire logic [1:0]       vid_mode,
    input  wire logic             sample_valid,
    input  wire logic [1:0][7:0]  pair_raw_temp,
    input  wire logic [1:0][7:0]  zone34_temp,
    input  wire logic [3:0][7:0]  boost_temp,
    input  wire logic [7:0]       base_duty,
    // results
    output logic      [7:0]       pwm_duty_q,
    output logic      [3:0]       boost_q,
    output logic      [1:0][11:0] filt_temp_q,
    output logic      [1:0][7:0]  temp_reading_q,
    output logic      [3:0][7:0]  zone_temp_q,
    output logic                  gen_input_a_low_threshold,
    output logic                  gen_input_b_low_threshold
);
    localparam int TW = $clog2(TICK_CYCLES);

    if (TICK_CYCLES < 2 || RAMP_STEP < 1 || RAMP_STEP > 255) begin : g_bad_param
        $error("unsupported tick or step setting");
    end

    logic [7:0]                level_sel_q;
    fan_ramp_pkg::ramp_pacing_t ramp_q;
    fan_ramp_pkg::hyst_pair_t  hyst_a_q;
    fan_ramp_pkg::hyst_pair_t  hyst_b_q;
    fan_ramp_pkg::smoothing_t  smooth_q;

    // register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_sel_q <= `RST_ZERO;
            ramp_q      <= `RST_ZERO;
            hyst_a_q    <= `RST_HYST;
            hyst_b_q    <= `RST_HYST;
            smooth_q    <= `RST_ZERO;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `ADDR_LEVEL_SEL: level_sel_q <= reg_wdata;
                `ADDR_RAMP_PACE: ramp_q <= reg_wdata;
                `ADDR_HYST_A:    hyst_a_q <= reg_wdata;
                `ADDR_HYST_B:    hyst_b_q <= reg_wdata;
                `ADDR_SMOOTH:    smooth_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // register reads, answer one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= `RST_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_LEVEL_SEL: reg_rdata_q <= level_sel_q;
                `ADDR_RAMP_PACE: reg_rdata_q <= ramp_q;
                `ADDR_HYST_A:    reg_rdata_q <= hyst_a_q;
                `ADDR_HYST_B:    reg_rdata_q <= hyst_b_q;
                `ADDR_SMOOTH:    reg_rdata_q <= smooth_q;
                default:         reg_rdata_q <= `RD_UNMAPPED;
            endcase
        end
    end

    // threshold selects are electrical; only the gating is logic here
    always_comb begin
        gen_input_a_low_threshold = level_sel_q[`LVL_GEN_A] && (vid_mode == `LEGACY_VID);
        gen_input_b_low_threshold = level_sel_q[`LVL_GEN_B] && (vid_mode == `LEGACY_VID);
    end

    // pin synchronisers, a level counts once stages two and three agree
    logic [2:0] reg_hot_sync_q;
    logic [2:0] thr_sync_q;
    logic       reg_hot_lvl_q;
    logic       thr_lvl_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_hot_sync_q <= 3'h0;
            thr_sync_q     <= 3'h0;
            reg_hot_lvl_q  <= 1'b0;
            thr_lvl_q      <= 1'b0;
        end else begin
            reg_hot_sync_q <= {reg_hot_sync_q[1:0], regulator_overheat_input};
            thr_sync_q     <= {thr_sync_q[1:0], processor_throttle_signal};
            if (reg_hot_sync_q[2] == reg_hot_sync_q[1]) begin
                reg_hot_lvl_q <= reg_hot_sync_q[2];
            end
            if (thr_sync_q[2] == thr_sync_q[1]) begin
                thr_lvl_q <= thr_sync_q[2];
            end
        end
    end

    // 50 ms timebase
    logic [TW-1:0] tick_cnt_q;
    logic          tick;
    assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : TW'(tick_cnt_q + 1'b1);
        end
    end

    // step wait follows the active source; ramp-down keeps the last one
    logic       last_src_thr_q;
    logic [3:0] cur_wait;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_src_thr_q <= 1'b0;
        end else if (reg_hot_lvl_q) begin
            last_src_thr_q <= 1'b0;
        end else if (thr_lvl_q) begin
            last_src_thr_q <= 1'b1;
        end
    end
    always_comb begin
        if (reg_hot_lvl_q || (!thr_lvl_q && !last_src_thr_q)) begin
            cur_wait = ramp_q.regulator_hot_step_wait;
        end else begin
            cur_wait = ramp_q.throttle_step_wait;
        end
    end

    // ramp engine
    fan_ramp_pkg::ramp_state_t state;
    logic [7:0] duty_q;
    logic [7:0] target;
    logic [3:0] step_cnt_q;
    logic [8:0] up_sum;
    logic [8:0] dn_floor;
    logic       step_due;
    assign target   = (reg_hot_lvl_q || thr_lvl_q) ? `FULL_DUTY : base_duty;
    assign up_sum   = {1'b0, duty_q} + 9'(RAMP_STEP);
    // nine bits so a high base duty cannot wrap the floor
    assign dn_floor = {1'b0, target} + 9'(RAMP_STEP);
    assign step_due = tick && (step_cnt_q + 4'h1 >= cur_wait);
    always_comb begin
        if (duty_q == target) begin
            state = fan_ramp_pkg::ST_FOLLOW;
        end else if (duty_q < target) begin
            state = fan_ramp_pkg::ST_UP;
        end else begin
            state = fan_ramp_pkg::ST_DOWN;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_q     <= `RST_ZERO;
            step_cnt_q <= 4'h0;
        end else if (state == fan_ramp_pkg::ST_FOLLOW) begin
            duty_q     <= target;
            step_cnt_q <= 4'h0;
        end else if (cur_wait == `ZERO_WAIT) begin
            duty_q     <= target;
            step_cnt_q <= 4'h0;
        end else if (step_due) begin
            step_cnt_q <= 4'h0;
            unique case (state)
                fan_ramp_pkg::ST_UP: begin
                    duty_q <= (up_sum >= {1'b0, target}) ? target : up_sum[7:0];
                end
                fan_ramp_pkg::ST_DOWN: begin
                    duty_q <= ({1'b0, duty_q} <= dn_floor) ? target : 8'(duty_q - RAMP_STEP);
                end
                default: duty_q <= target;
            endcase
        end else if (tick) begin
            step_cnt_q <= step_cnt_q + 4'h1;
        end
    end

    // span code to filter shift; assumes about one sample per 0.2 s
    function automatic logic [2:0] span_shift(input logic [2:0] code);
        unique case (code)
            3'h0: span_shift = 3'h6;
            3'h1: span_shift = 3'h5;
            3'h2: span_shift = 3'h5;
            3'h3: span_shift = 3'h4;
            3'h4: span_shift = 3'h3;
            3'h5: span_shift = 3'h2;
            3'h6: span_shift = 3'h2;
            default: span_shift = 3'h1;
        endcase
    endfunction

    // smoothing filters, separate from converter averaging
    logic [1:0] primed_q;
    logic [1:0] use_filt;
    logic [1:0][2:0] span;
    assign use_filt = {smooth_q.smooth_use_second_pair, smooth_q.smooth_use_first_pair};
    assign span     = {smooth_q.smooth_span_second_pair, smooth_q.smooth_span_first_pair};
    for (genvar p = 0; p < 2; p++) begin : g_filt
        logic signed [12:0] diff;
        logic signed [12:0] nxt;
        always_comb begin
            diff = $signed({1'b0, pair_raw_temp[p], 4'h0}) - $signed({1'b0, filt_temp_q[p]});
            nxt  = $signed({1'b0, filt_temp_q[p]}) + (diff >>> span_shift(span[p]));
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                filt_temp_q[p] <= 12'h000;
                primed_q[p]    <= 1'b0;
            end else if (sample_valid) begin
                primed_q[p] <= 1'b1;
                // first sample seeds the filter to avoid a slow climb from zero
                filt_temp_q[p] <= primed_q[p] ? nxt[11:0] : {pair_raw_temp[p], 4'h0};
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                temp_reading_q[p] <= `RST_ZERO;
                zone_temp_q[p]    <= `RST_ZERO;
            end else begin
                temp_reading_q[p] <= pair_raw_temp[p];
                zone_temp_q[p]    <= use_filt[p] ? filt_temp_q[p][11:`FRAC_BITS] : pair_raw_temp[p];
            end
        end
    end

    // boost with hysteresis per zone
    logic [3:0][3:0] hyst;
    assign hyst = {hyst_b_q.hi, hyst_b_q.lo, hyst_a_q.hi, hyst_a_q.lo};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zone_temp_q[2] <= `RST_ZERO;
            zone_temp_q[3] <= `RST_ZERO;
        end else begin
            zone_temp_q[2] <= zone34_temp[0];
            zone_temp_q[3] <= zone34_temp[1];
        end
    end
    for (genvar z = 0; z < 4; z++) begin : g_boost
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                boost_q[z] <= 1'b0;
            end else if (zone_temp_q[z] > boost_temp[z]) begin
                boost_q[z] <= 1'b1;
            end else if ({1'b0, zone_temp_q[z]} + {5'h00, hyst[z]} < {1'b0, boost_temp[z]}) begin
                boost_q[z] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_duty_q <= `RST_ZERO;
        end else begin
            pwm_duty_q <= (|boost_q) ? `FULL_DUTY : duty_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence hot_zero_wait_s;
        (reg_hot_lvl_q || thr_lvl_q) && (cur_wait == `ZERO_WAIT);
    endsequence
    sequence boost_quiet_s;
        !(|boost_q);
    endsequence

    zero_wait_jump_a: assert property (hot_zero_wait_s |=> duty_q == `FULL_DUTY)
        else $error("zero wait did not jump to full");
    reg_wait_sel_a: assert property (reg_hot_lvl_q |-> cur_wait == ramp_q.regulator_hot_step_wait)
        else $error("regulator wait not selected");
    thr_wait_sel_a: assert property (thr_lvl_q && !reg_hot_lvl_q |-> cur_wait == ramp_q.throttle_step_wait)
        else $error("throttle wait not selected");
    step_pacing_a: assert property (cur_wait != `ZERO_WAIT && !tick && state != fan_ramp_pkg::ST_FOLLOW
                                    |=> $stable(duty_q))
        else $error("duty stepped between ticks");
    boost_full_a: assert property ((|boost_q) |=> pwm_duty_q == `FULL_DUTY)
        else $error("boost did not force full duty");
    boost_hold_a: assert property (boost_q[0] && ({1'b0, zone_temp_q[0]} + {5'h00, hyst_a_q.lo}
                                   >= {1'b0, boost_temp[0]}) |=> boost_q[0])
        else $error("boost released inside hysteresis");
    boost_release_a: assert property (boost_q[3] && ({1'b0, zone_temp_q[3]} + {5'h00, hyst_b_q.hi}
                                      < {1'b0, boost_temp[3]}) |=> !boost_q[3])
        else $error("boost not released below hysteresis");
    quiet_follow_a: assert property (boost_quiet_s ##1 boost_quiet_s |-> pwm_duty_q == $past(duty_q))
        else $error("duty output not following ramp");
    filt_use_one_a: assert property (smooth_q.smooth_use_first_pair && $stable(smooth_q)
                                     |-> zone_temp_q[0] == $past(filt_temp_q[0][11:`FRAC_BITS]))
        else $error("first pair not using filtered value");
    filt_use_two_a: assert property (!smooth_q.smooth_use_second_pair && $stable(smooth_q) && $past(rst_n)
                                     |-> zone_temp_q[1] == $past(pair_raw_temp[1]))
        else $error("second pair not using raw value");
    raw_reading_a: assert property (##1 temp_reading_q[0] == $past(pair_raw_temp[0]))
        else $error("reading register not raw");
    filt_update_a: assert property (sample_valid && !primed_q[0] |=> filt_temp_q[0] == {$past(pair_raw_temp[0]), 4'h0})
        else $error("filter did not take sample");
    legacy_gate_a: assert property (vid_mode != `LEGACY_VID |-> !gen_input_a_low_threshold && !gen_input_b_low_threshold)
        else $error("threshold select active outside legacy mode");
endmodule
`default_nettype wire

/* File: logic/fan_ramp_regs.svh */
`ifndef FAN_RAMP_REGS_SVH
`define FAN_RAMP_REGS_SVH
`define ADDR_LEVEL_SEL 8'hbe
`define ADDR_RAMP_PACE 8'hbf
`define ADDR_HYST_A    8'hc0
`define ADDR_HYST_B    8'hc1
`define ADDR_SMOOTH    8'hc2
`define RST_ZERO       8'h00
`define RST_HYST       8'h44
`define RD_UNMAPPED    8'h00
`define FULL_DUTY      8'hff
`define ZERO_WAIT      4'h0
`define LEGACY_VID     2'h0
`define LVL_GEN_A      2
`define LVL_GEN_B      3
`define STEP_MS        50
`define CLK_KHZ        20000
`define FRAC_BITS      4
`endif

/* File: logic/fan_ramp_pkg.sv */
`default_nettype none
package fan_ramp_pkg;
    typedef struct packed {
        logic [3:0] throttle_step_wait;
        logic [3:0] regulator_hot_step_wait;
    } ramp_pacing_t;
    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } hyst_pair_t;
    typedef struct packed {
        logic       smooth_use_second_pair;
        logic [2:0] smooth_span_second_pair;
        logic       smooth_use_first_pair;
        logic [2:0] smooth_span_first_pair;
    } smoothing_t;
    typedef enum logic [2:0] {
        ST_FOLLOW = 3'b001,
        ST_UP     = 3'b010,
        ST_DOWN   = 3'b100
    } ramp_state_t;
endpackage
`default_nettype wire

/* File: tb/fan_model.sv */
`timescale 1ns/1ps
`default_nettype none
// fan rotor lags the commanded duty, slewing one count a cycle
module fan_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // drive and response
    input  wire logic [7:0] duty,
    output logic      [7:0] speed_q
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_q <= 8'h00;
        end else if (speed_q < duty) begin
            speed_q <= speed_q + 8'h01;
        end else if (speed_q > duty) begin
            speed_q <= speed_q - 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_fan_ramp_boost_smoothing.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end
module tb_fan_ramp_boost_smoothing;
    logic             clk, rst_n, reg_wr, reg_rd, reg_hot, thr_hot, sample_valid;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata_q, base_duty, pwm_duty_q, speed_q, rd;
    logic [1:0]       vid_mode;
    logic [1:0][7:0]  pair_raw_temp, zone34_temp, temp_reading_q;
    logic [3:0][7:0]  boost_temp, zone_temp_q;
    logic [3:0]       boost_q;
    logic [1:0][11:0] filt_temp_q;
    logic             lvl_a, lvl_b;
    int               mismatches, checked, cyc;

    fan_ramp_boost_smoothing #(.TICK_CYCLES(20), .RAMP_STEP(16)) fan_ramp_boost_smoothing_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .regulator_overheat_input(reg_hot),
        .processor_throttle_signal(thr_hot), .vid_mode(vid_mode), .sample_valid(sample_valid),
        .pair_raw_temp(pair_raw_temp), .zone34_temp(zone34_temp), .boost_temp(boost_temp),
        .base_duty(base_duty), .pwm_duty_q(pwm_duty_q), .boost_q(boost_q), .filt_temp_q(filt_temp_q),
        .temp_reading_q(temp_reading_q), .zone_temp_q(zone_temp_q),
        .gen_input_a_low_threshold(lvl_a), .gen_input_b_low_threshold(lvl_b));
    fan_model fan_model_inst (.clk(clk), .rst_n(rst_n), .duty(pwm_duty_q), .speed_q(speed_q));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic tally_and_finish;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard, a run needs about 3200 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish;
        end
    end

    task automatic do_reset;
        rst_n = 1'b0;
        reg_hot = 1'b0;
        thr_hot = 1'b0;
        step(6);
        rst_n = 1'b1;
        step(1);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask

    task automatic reg_read(input logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        step(1);
        rd = reg_rdata_q;
    endtask

    task automatic sample(input logic [7:0] t0, input logic [7:0] t1, input logic [7:0] t2, input logic [7:0] t3);
        pair_raw_temp = {t1, t0};
        zone34_temp = {t3, t2};
        sample_valid = 1'b1;
        step(1);
        sample_valid = 1'b0;
        step(4);
    endtask

    task automatic t_regs;
        logic [7:0] adr [5] = '{8'hbe, 8'hbf, 8'hc0, 8'hc1, 8'hc2};
        logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h44, 8'h44, 8'h00};
        logic [7:0] val [5] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h81};
        do_reset();
        for (int i = 0; i < 5; i++) begin
            reg_read(adr[i]);
            `CHK(rd, rst[i], "register reset value")
            reg_write(adr[i], val[i]);
            reg_read(adr[i]);
            `CHK(rd, val[i], "register readback")
        end
        reg_write(8'hc3, 8'hff);
        reg_read(8'hc3);
        `CHK(rd, 8'h00, "unmapped read")
    endtask

    task automatic t_levels;
        do_reset();
        reg_write(8'hbe, 8'h0c);
        vid_mode = 2'h0;
        step(1);
        `CHK({lvl_a, lvl_b}, 2'b11, "thresholds in legacy mode")
        vid_mode = 2'h1;
        step(1);
        `CHK({lvl_a, lvl_b}, 2'b00, "thresholds outside legacy mode")
        vid_mode = 2'h0;
        reg_write(8'hbe, 8'h08);
        `CHK({lvl_a, lvl_b}, 2'b01, "second threshold alone")
    endtask

    // slow ramps step 16 every two 20-cycle ticks, so full duty needs 640 cycles
    task automatic t_ramp(input logic [7:0] pace, input logic use_reg, input logic jump);
        do_reset();
        base_duty = 8'h00;
        reg_write(8'hbf, pace);
        reg_hot = use_reg;
        thr_hot = ~use_reg;
        step(10);
        if (jump) begin
            `CHK(pwm_duty_q, 8'hff, "zero wait jump")
        end else begin
            `CHK(pwm_duty_q, 8'h00, "no jump with nonzero wait")
            step(90);
            `CHK(pwm_duty_q >= 8'h10 && pwm_duty_q <= 8'h40, 1'b1, "partial ramp")
            step(700);
            `CHK(pwm_duty_q, 8'hff, "ramp reaches full")
        end
        step(300);
        `CHK(speed_q, 8'hff, "fan at full speed")
        reg_hot = 1'b0;
        thr_hot = 1'b0;
        if (jump) begin
            step(10);
            `CHK(pwm_duty_q, 8'h00, "zero wait drops at once")
        end else begin
            step(60);
            `CHK(pwm_duty_q >= 8'hc0 && pwm_duty_q < 8'hff, 1'b1, "ramp down paced by last source")
        end
    endtask

    task automatic t_boost;
        logic [7:0] hy [4] = '{8'd3, 8'd7, 8'd0, 8'd15};
        logic [3:0][7:0] t;
        do_reset();
        reg_write(8'hc0, 8'h73);
        reg_write(8'hc1, 8'hf0);
        boost_temp = {4{8'd60}};
        base_duty = 8'h20;
        for (int i = 0; i < 4; i++) begin
            t = '0;
            t[i] = 8'd61;
            sample(t[0], t[1], t[2], t[3]);
            `CHK({boost_q, pwm_duty_q}, {4'h1 << i, 8'hff}, "boost set")
            `CHK(zone_temp_q, t, "zone temperatures follow inputs")
            t[i] = 8'd60 - hy[i];
            sample(t[0], t[1], t[2], t[3]);
            `CHK({boost_q, pwm_duty_q}, {4'h1 << i, 8'hff}, "boost held at hysteresis edge")
            t[i] = 8'd59 - hy[i];
            sample(t[0], t[1], t[2], t[3]);
            `CHK({boost_q, pwm_duty_q}, {4'h0, 8'h20}, "boost released")
        end
    endtask

    // span 7 shifts by 1, span 4 shifts by 3
    task automatic t_filter;
        logic [7:0]  ctl [3] = '{8'h10, 8'h32, 8'h65};
        logic [23:0] want [3] = '{24'h2e6_37b, 24'h31b_391, 24'h3e4_43c};
        do_reset();
        reg_write(8'hc2, 8'h47);
        sample(8'd40, 8'd40, 8'd0, 8'd0);
        `CHK(filt_temp_q, {12'h280, 12'h280}, "first sample loads")
        sample(8'd60, 8'd60, 8'd0, 8'd0);
        `CHK(filt_temp_q, {12'h2a8, 12'h320}, "filter spans")
        `CHK(zone_temp_q[1:0], {8'd60, 8'd60}, "raw used while off")
        reg_write(8'hc2, 8'hcf);
        sample(8'd60, 8'd60, 8'd0, 8'd0);
        `CHK(filt_temp_q, {12'h2cb, 12'h370}, "filter keeps running")
        `CHK(zone_temp_q[1:0], {8'h2c, 8'h37}, "filtered used while on")
        `CHK(temp_reading_q, {8'd60, 8'd60}, "readings stay raw")
        // remaining span codes, shifts 6 5 5 4 2 2
        for (int i = 0; i < 3; i++) begin
            reg_write(8'hc2, ctl[i]);
            sample(8'd100, 8'd100, 8'd0, 8'd0);
            `CHK(filt_temp_q, want[i], "span codes")
        end
        `CHK(zone_temp_q[1:0], {8'd100, 8'd100}, "raw used after use bits clear")
    endtask

    initial begin
        {reg_wr, reg_rd, sample_valid, reg_hot, thr_hot} = '0;
        {reg_addr, reg_wdata, base_duty, vid_mode} = '0;
        {pair_raw_temp, zone34_temp, boost_temp} = '0;
        mismatches = 0;
        checked = 0;
        cyc = 0;
        t_regs();
        t_levels();
        t_ramp(8'h02, 1'b1, 1'b0);
        t_ramp(8'h20, 1'b1, 1'b1);
        t_ramp(8'h02, 1'b0, 1'b1);
        t_ramp(8'h20, 1'b0, 1'b0);
        t_boost();
        t_filter();
        tally_and_finish();
    end
endmodule
`default_nettype wire
